// ==== tsc_pkg.sv ====
package tsc_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_GR = 4;
  // word index inside one channel block, byte address bits [4:2]
  localparam logic [2:0] REG_STAT = 3'h0;
  localparam logic [2:0] REG_CNT = 3'h1;
  localparam logic [2:0] REG_GRA = 3'h2;
  localparam logic [2:0] REG_GRB = 3'h3;
  localparam logic [2:0] REG_GRC = 3'h4;
  localparam logic [2:0] REG_GRD = 3'h5;
  localparam logic [2:0] REG_CTRL = 3'h6;
  // channel block stride 0x20, channel number in address bits [7:5]
  localparam int CH_LSB = 5;
  localparam int IDX_LSB = 2;
  // control register fields
  localparam int CTL_RUN = 0;
  localparam int CTL_PHASE = 1;
  localparam int CTL_CPWM = 2;
  localparam int CTL_CAP = 3;
  localparam int CTL_BUF = 7;
  localparam int CTL_W = 9;
  localparam logic [CTL_W-1:0] CTRL_RST = 9'h000;
  // status flag positions
  localparam int FLG_A = 0;
  localparam int FLG_B = 1;
  localparam int FLG_C = 2;
  localparam int FLG_D = 3;
  localparam int FLG_OVF = 4;
  localparam int FLG_UNF = 5;
  localparam logic [5:0] FLG_RST = 6'h00;
  localparam logic [5:0] MASK_2REG = 6'h33;
  localparam logic [5:0] MASK_4REG = 6'h1F;
  localparam logic [7:0] STAT_RST = 8'hC0;
  // counter and general register values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== tsc_timer_status.sv ====
`timescale 1ns/1ps
module tsc_timer_status
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // counting
  input wire logic [NUM_CH-1:0] count_tick,
  input wire logic [NUM_CH-1:0] phase_down,
  input wire logic [NUM_CH*NUM_GR-1:0] capture_in,
  // transfer acknowledges
  input wire logic [NUM_CH-1:0] dma_ack_a,
  input wire logic [NUM_CH-1:0] xfer_ack_b,
  input wire logic [NUM_CH-1:0] xfer_ack_c,
  input wire logic [NUM_CH-1:0] xfer_ack_d,
  input wire logic xfer_ack_ovf4,
  // status out
  output logic [NUM_CH-1:0] count_dir_flag
);

  logic init;
  logic wr_en;
  logic wr_ok;
  logic wr_full;
  logic rd_en;
  logic rd_ok;
  logic [2:0] wch;
  logic [2:0] widx;
  logic [2:0] rch;
  logic [2:0] ridx;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] rd_word;
  logic [15:0] cnt_q [NUM_CH];
  logic [15:0] gr_q [NUM_CH][NUM_GR];
  logic [5:0] flg_q [NUM_CH];
  logic [5:0] seen_q [NUM_CH];
  logic [CTL_W-1:0] ctrl_q [NUM_CH];
  logic up_q [NUM_CH];
  logic [7:0] stat_w [NUM_CH];

  assign init = !aresetn || standby;

  function automatic logic map_ok(input logic [11:0] a);
    logic [2:0] ch;
    logic [2:0] ix;
    ch = a[CH_LSB+2:CH_LSB];
    ix = a[IDX_LSB+2:IDX_LSB];
    map_ok = (a[11:8] == 4'h0) && (ch < 3'h5) && (ix <= REG_CTRL);
    if ((ch == 3'h1 || ch == 3'h2) && (ix == REG_GRC || ix == REG_GRD)) begin
      map_ok = 1'b0;
    end
  endfunction

  // write channel: address and data taken together
  assign wr_en = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_en;
  assign s_axi_wready = wr_en;
  assign wr_ok = map_ok(s_axi_awaddr);
  assign wr_full = (s_axi_wstrb[1:0] == 2'h3);
  assign wch = s_axi_awaddr[CH_LSB+2:CH_LSB];
  assign widx = s_axi_awaddr[IDX_LSB+2:IDX_LSB];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel
  assign rd_en = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign rd_ok = map_ok(s_axi_araddr);
  assign rch = s_axi_araddr[CH_LSB+2:CH_LSB];
  assign ridx = s_axi_araddr[IDX_LSB+2:IDX_LSB];
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (rch == 3'(i)) begin
        case (ridx)
          REG_STAT: rd_word = {8'h00, stat_w[i]};
          REG_CNT: rd_word = cnt_q[i];
          REG_GRA: rd_word = gr_q[i][0];
          REG_GRB: rd_word = gr_q[i][1];
          REG_GRC: rd_word = gr_q[i][2];
          REG_GRD: rd_word = gr_q[i][3];
          REG_CTRL: rd_word = {7'h00, ctrl_q[i]};
          default: rd_word = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (rd_en) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_ok ? {16'h0000, rd_word} : 32'h00000000;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int NREG = (c == 1 || c == 2) ? 2 : 4;
    localparam logic [5:0] FMASK = (NREG == 2) ? MASK_2REG : MASK_4REG;
    logic sel_w;
    logic wr_st;
    logic wr_cnt;
    logic wr_ctl;
    logic rd_st;
    logic up;
    logic tick;
    logic ovf_ev;
    logic unf_ev;
    logic [3:0] wr_gr;
    logic [3:0] is_buf;
    logic [3:0] hit;
    logic [3:0] cap;
    logic [5:0] set_f;
    logic [5:0] clr_f;
    logic [5:0] ack_f;
    logic [15:0] cnt_d;

    assign sel_w = wr_en && wr_ok && wr_full && (wch == 3'(c));
    assign wr_st = sel_w && (widx == REG_STAT);
    assign wr_cnt = sel_w && (widx == REG_CNT);
    assign wr_ctl = sel_w && (widx == REG_CTRL);
    assign rd_st = rd_en && rd_ok && (rch == 3'(c)) && (ridx == REG_STAT);

    // count direction per channel type
    always_comb begin
      if (c == 0) begin
        up = 1'b1;
      end else if (c <= 2) begin
        up = !(ctrl_q[c][CTL_PHASE] && phase_down[c]);
      end else begin
        up = !ctrl_q[c][CTL_CPWM] || up_q[c];
      end
    end

    assign tick = count_tick[c] && ctrl_q[c][CTL_RUN] && !wr_cnt;
    assign cnt_d = up ? cnt_q[c] + CNT_ONE : cnt_q[c] - CNT_ONE;
    assign ovf_ev = tick && ((up && cnt_q[c] == CNT_MAX)
      || (c == 4 && ctrl_q[c][CTL_CPWM] && !up && cnt_q[c] == CNT_ONE));
    assign unf_ev = tick && (c == 1 || c == 2) && !up && cnt_q[c] == CNT_MIN;

    // counter
    always_ff @(posedge aclk) begin
      if (init) begin
        cnt_q[c] <= CNT_RST;
      end else if (wr_cnt) begin
        cnt_q[c] <= s_axi_wdata[15:0];
      end else if (tick) begin
        cnt_q[c] <= cnt_d;
      end
    end

    // turn-around in complementary pwm: peak at register a, valley at zero
    always_ff @(posedge aclk) begin
      if (init) begin
        up_q[c] <= 1'b1;
      end else if (!ctrl_q[c][CTL_CPWM] || c < 3) begin
        up_q[c] <= 1'b1;
      end else if (tick && up_q[c] && cnt_d == gr_q[c][0]) begin
        up_q[c] <= 1'b0;
      end else if (tick && !up_q[c] && cnt_q[c] == CNT_ONE) begin
        up_q[c] <= 1'b1;
      end
    end

    always_ff @(posedge aclk) begin
      if (init) begin
        ctrl_q[c] <= CTRL_RST;
      end else if (wr_ctl) begin
        ctrl_q[c] <= s_axi_wdata[CTL_W-1:0];
      end
    end

    // compare and capture per general register
    for (genvar r = 0; r < NUM_GR; r++) begin : g_gr
      assign wr_gr[r] = sel_w && (widx == REG_GRA + 3'(r));
      assign is_buf[r] = (r >= 2) && (NREG == 4) && ctrl_q[c][CTL_BUF + (r % 2)];
      assign hit[r] = (r < NREG) && !is_buf[r] && !ctrl_q[c][CTL_CAP + r]
        && tick && cnt_q[c] == gr_q[c][r];
      assign cap[r] = (r < NREG) && !is_buf[r] && ctrl_q[c][CTL_CAP + r]
        && capture_in[c*NUM_GR + r];

      always_ff @(posedge aclk) begin
        if (init) begin
          gr_q[c][r] <= GR_RST;
        end else if (r >= NREG) begin
          gr_q[c][r] <= GR_RST;
        end else if (cap[r]) begin
          gr_q[c][r] <= cnt_q[c];
        end else if (r < 2 && hit[r] && ctrl_q[c][CTL_BUF + (r % 2)] && NREG == 4) begin
          gr_q[c][r] <= gr_q[c][(r + 2) % NUM_GR];
        end else if (wr_gr[r]) begin
          gr_q[c][r] <= s_axi_wdata[15:0];
        end
      end
    end

    assign set_f = {unf_ev, ovf_ev, hit | cap};
    assign ack_f = {1'b0, (c == 4) && xfer_ack_ovf4,
      xfer_ack_d[c], xfer_ack_c[c], xfer_ack_b[c],
      dma_ack_a[c]};
    assign clr_f = (wr_st ? (~s_axi_wdata[5:0] & seen_q[c]) : 6'h00) | ack_f;

    // flags: set beats clear in the same cycle
    always_ff @(posedge aclk) begin
      if (init) begin
        flg_q[c] <= FLG_RST;
      end else begin
        flg_q[c] <= ((flg_q[c] & ~clr_f) | set_f) & FMASK;
      end
    end

    // flags seen as 1 by a status read arm their clear
    always_ff @(posedge aclk) begin
      if (init) begin
        seen_q[c] <= FLG_RST;
      end else begin
        seen_q[c] <= (seen_q[c] | (rd_st ? flg_q[c] : 6'h00)) & ~clr_f & flg_q[c];
      end
    end

    assign count_dir_flag[c] = (c == 0) ? 1'b1 : up;
    assign stat_w[c] = {count_dir_flag[c], STAT_RST[6], flg_q[c]};
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (init);

  a_ovf_set_ch0: assert property (
    g_ch[0].tick && cnt_q[0] == CNT_MAX |=> flg_q[0][FLG_OVF] && cnt_q[0] == CNT_MIN)
    else $error("overflow flag not set on wrap");

  a_unf_set_ch1: assert property (
    g_ch[1].tick && !g_ch[1].up && cnt_q[1] == CNT_MIN
    |=> flg_q[1][FLG_UNF] && cnt_q[1] == CNT_MAX)
    else $error("underflow flag not set on wrap");

  a_cpwm_ovf_ch4: assert property (
    g_ch[4].tick && ctrl_q[4][CTL_CPWM] && !g_ch[4].up && cnt_q[4] == CNT_ONE
    |=> flg_q[4][FLG_OVF] && up_q[4])
    else $error("valley did not set overflow");

  a_ch0_counts_up: assert property (
    g_ch[0].tick |=> cnt_q[0] == $past(cnt_q[0]) + CNT_ONE)
    else $error("channel 0 did not increment");

  a_flag_unread_held: assert property (
    flg_q[0][FLG_A] && !seen_q[0][FLG_A] && !dma_ack_a[0] |=> flg_q[0][FLG_A])
    else $error("unread flag was cleared");

  a_set_beats_clear: assert property (
    g_ch[3].set_f[FLG_B] |=> flg_q[3][FLG_B])
    else $error("flag set lost to clear");

  a_dma_clears_a: assert property (
    dma_ack_a[0] && !g_ch[0].set_f[FLG_A] |=> !flg_q[0][FLG_A])
    else $error("dma transfer did not clear flag");

  a_capture_copy: assert property (
    g_ch[2].cap[0] |=> gr_q[2][0] == $past(cnt_q[2]) && flg_q[2][FLG_A])
    else $error("capture did not copy counter");

  a_match_flag: assert property (
    g_ch[3].hit[2] |=> flg_q[3][FLG_C])
    else $error("compare match flag not set");

  a_cd_read_zero: assert property (
    flg_q[1][FLG_D:FLG_C] == 2'h0 && flg_q[2][FLG_D:FLG_C] == 2'h0)
    else $error("missing register flags not zero");

  a_standby_init: assert property (
    disable iff (!aresetn) standby |=> cnt_q[2] == CNT_RST && gr_q[2][1] == GR_RST
    && stat_w[2] == STAT_RST)
    else $error("standby did not initialise channel");

  a_write_one_keeps: assert property (
    g_ch[0].wr_st && s_axi_wdata[FLG_OVF] && flg_q[0][FLG_OVF] |=> flg_q[0][FLG_OVF])
    else $error("writing one cleared a flag");

  a_ovf4_xfer_clear: assert property (
    xfer_ack_ovf4 && !g_ch[4].set_f[FLG_OVF] |=> !flg_q[4][FLG_OVF])
    else $error("transfer did not clear overflow flag");

  a_xfer_clears_b: assert property (
    xfer_ack_b[0] && !g_ch[0].set_f[FLG_B] |=> !flg_q[0][FLG_B])
    else $error("transfer did not clear flag b");

  a_cnt_write: assert property (
    g_ch[1].wr_cnt |=> cnt_q[1] == $past(s_axi_wdata[15:0]))
    else $error("counter write lost");

  a_gr_write: assert property (
    g_ch[1].wr_gr[1] && !g_ch[1].cap[1] |=> gr_q[1][1] == $past(s_axi_wdata[15:0]))
    else $error("general register write lost");

  a_buffer_load: assert property (
    g_ch[3].hit[0] && ctrl_q[3][CTL_BUF] |=> gr_q[3][0] == $past(gr_q[3][2]))
    else $error("buffer did not load register a");

  a_up_without_pwm: assert property (
    !ctrl_q[3][CTL_CPWM] |-> count_dir_flag[3])
    else $error("channel 3 counts down outside pwm mode");

endmodule // tsc_timer_status

// ==== tsc_xfer_model.sv ====
`timescale 1ns/1ps
module tsc_xfer_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // transfer request: kind 0-3 flag a-d, 4 channel 4 overflow
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [2:0] ch,
  input wire logic [3:0] lat,
  // acknowledge pulses
  output logic [4:0] dma_ack_a,
  output logic [4:0] xfer_ack_b,
  output logic [4:0] xfer_ack_c,
  output logic [4:0] xfer_ack_d,
  output logic xfer_ack_ovf4
);
  logic act_q;
  logic [3:0] cnt_q;
  logic [2:0] kind_q;
  logic [2:0] ch_q;

  // one acknowledge pulse, lat + 1 cycles after the clock edge that takes the request
  always_ff @(posedge aclk) begin
    dma_ack_a <= 5'h00;
    xfer_ack_b <= 5'h00;
    xfer_ack_c <= 5'h00;
    xfer_ack_d <= 5'h00;
    xfer_ack_ovf4 <= 1'b0;
    if (!aresetn) begin
      act_q <= 1'b0;
    end else if (go) begin
      act_q <= 1'b1;
      cnt_q <= lat;
      kind_q <= kind;
      ch_q <= ch;
    end else if (act_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (act_q) begin
      act_q <= 1'b0;
      case (kind_q)
        3'h0: dma_ack_a[ch_q] <= 1'b1;
        3'h1: xfer_ack_b[ch_q] <= 1'b1;
        3'h2: xfer_ack_c[ch_q] <= 1'b1;
        3'h3: xfer_ack_d[ch_q] <= 1'b1;
        default: xfer_ack_ovf4 <= 1'b1;
      endcase
    end
  end
endmodule // tsc_xfer_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  import tsc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic standby = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, seed = 32'h720F;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [4:0] count_tick = '0, phase_down = '0, count_dir_flag;
  logic [4:0] dma_ack_a, xfer_ack_b, xfer_ack_c, xfer_ack_d;
  logic [19:0] capture_in = '0;
  logic xfer_ack_ovf4, go = 1'b0;
  logic [2:0] kind = '0, ch = '0;
  logic [3:0] lat = '0;
  logic [15:0] v;
  int err_total = 0, checks_done = 0, cyc = 0;

  tsc_timer_status u_tsc_timer_status (.aclk, .aresetn, .standby, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .count_tick, .phase_down, .capture_in, .dma_ack_a, .xfer_ack_b,
    .xfer_ack_c, .xfer_ack_d, .xfer_ack_ovf4, .count_dir_flag);
  tsc_xfer_model u_tsc_xfer_model (.aclk, .aresetn, .go, .kind, .ch, .lat, .dma_ack_a,
    .xfer_ack_b, .xfer_ack_c, .xfer_ack_d, .xfer_ack_ovf4);

  always #4 aclk = ~aclk;

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] ad(input int c, input int r);
    return 12'(c * 32 + r * 4);
  endfunction
  function automatic logic [31:0] st(input logic d, input logic [5:0] f);
    return {24'h000000, d, 1'b1, f};
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // full word strobes only, so no byte-wide access
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    chk(nm, rd, e);
  endtask
  task automatic tk(input int c, input int n);
    repeat (n) begin
      count_tick[c] <= 1'b1;
      @(posedge aclk);
      count_tick[c] <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task automatic xf(input int k, input int c, input int l);
    go <= 1'b1;
    kind <= 3'(k);
    ch <= 3'(c);
    lat <= 4'(l);
    @(posedge aclk);
    go <= 1'b0;
    repeat (l + 3) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int c = 0; c < 5; c++) begin
      rc("status", ad(c, REG_STAT), st(1'b1, 6'h00));
      rc("counter", ad(c, REG_CNT), 32'h0);
      rc("gen a", ad(c, REG_GRA), 32'h0000FFFF);
    end
    rc("ch1 gen c", ad(1, REG_GRC), 32'h0);
    chk("rresp", 32'(rs), 32'(RESP_SLVERR));
    wr(12'hA00, 32'h0);
    chk("bresp", 32'(rs), 32'(RESP_SLVERR));
    $display("test reset done");
    for (int c = 0; c < 5; c++) begin
      seed = nx(seed);
      wr(ad(c, REG_CNT), seed);
      rc("cnt rw", ad(c, REG_CNT), {16'h0000, seed[15:0]});
      seed = nx(seed);
      wr(ad(c, REG_GRB), seed);
      rc("gen rw", ad(c, REG_GRB), {16'h0000, seed[15:0]});
    end
    $display("test rw done");
    wr(ad(0, REG_CTRL), 32'h1);
    wr(ad(0, REG_CNT), 32'hFFFF);
    tk(0, 1);
    rc("ovf cnt", ad(0, REG_CNT), 32'h0);
    wr(ad(0, REG_STAT), 32'h0);
    rc("unread", ad(0, REG_STAT), st(1'b1, 6'h1D));
    wr(ad(0, REG_STAT), 32'h11);
    rc("write one", ad(0, REG_STAT), st(1'b1, 6'h11));
    wr(ad(0, REG_STAT), 32'h0);
    rc("cleared", ad(0, REG_STAT), st(1'b1, 6'h00));
    $display("test overflow done");
    phase_down <= 5'h02;
    wr(ad(1, REG_CTRL), 32'h3);
    wr(ad(1, REG_CNT), 32'h0);
    tk(1, 1);
    chk("dir", 32'(count_dir_flag), 32'h1D);
    rc("unf cnt", ad(1, REG_CNT), 32'hFFFF);
    rc("unf stat", ad(1, REG_STAT), st(1'b0, 6'h20));
    $display("test underflow done");
    seed = nx(seed);
    v = seed[15:0] & 16'h7FFF;
    wr(ad(3, REG_GRA), {16'h0000, v});
    wr(ad(3, REG_CNT), {16'h0000, v});
    wr(ad(3, REG_CTRL), 32'h1);
    tk(3, 1);
    rc("match", ad(3, REG_STAT), st(1'b1, 6'h01));
    xf(0, 3, 0);
    rc("dma clr", ad(3, REG_STAT), st(1'b1, 6'h00));
    $display("test compare done");
    wr(ad(3, REG_GRC), 32'h1234);
    wr(ad(3, REG_GRA), 32'h5);
    wr(ad(3, REG_CNT), 32'h5);
    wr(ad(3, REG_CTRL), 32'h81);
    tk(3, 1);
    rc("buf load", ad(3, REG_GRA), 32'h00001234);
    rc("buf keep", ad(3, REG_GRC), 32'h00001234);
    $display("test buffer done");
    seed = nx(seed);
    wr(ad(0, REG_CTRL), 32'h078);
    wr(ad(0, REG_CNT), {16'h0000, seed[15:0]});
    capture_in <= 20'h0000F;
    @(posedge aclk);
    capture_in <= 20'h00000;
    @(posedge aclk);
    for (int r = 0; r < 4; r++)
      rc("capt", ad(0, REG_GRA + r), {16'h0000, seed[15:0]});
    rc("capt flags", ad(0, REG_STAT), st(1'b1, 6'h0F));
    for (int k = 0; k < 4; k++) begin
      xf(k, 0, 5);
      rc("xfer clr", ad(0, REG_STAT), st(1'b1, 6'h0F & (6'h0F << (k + 1))));
    end
    $display("test capture done");
    wr(ad(4, REG_GRA), 32'h2);
    wr(ad(4, REG_GRB), 32'hFFFF);
    wr(ad(4, REG_CNT), 32'h0);
    wr(ad(4, REG_CTRL), 32'h5);
    tk(4, 2);
    chk("pwm dir", 32'(count_dir_flag), 32'h0D);
    tk(4, 2);
    rc("pwm cnt", ad(4, REG_CNT), 32'h0);
    rc("pwm stat", ad(4, REG_STAT), st(1'b1, 6'h11));
    chk("pwm ovf", rd & 32'h10, 32'h10);
    xf(4, 4, 0);
    rc("ovf clr", ad(4, REG_STAT), st(1'b1, 6'h01));
    chk("ovf clr", rd & 32'h10, 32'h0);
    $display("test pwm done");
    standby <= 1'b1;
    repeat (2) @(posedge aclk);
    standby <= 1'b0;
    @(posedge aclk);
    rc("sby cnt", ad(2, REG_CNT), 32'h0);
    rc("sby gen", ad(0, REG_GRB), 32'h0000FFFF);
    rc("sby stat", ad(4, REG_STAT), st(1'b1, 6'h00));
    $display("test standby done");
    close_out();
  end
endmodule // tb
